// *** plmcr_regs.vh ***
// Register offsets, field positions, reset values and encodings for the loopback/management/config bank
`ifndef PLMCR_REGS_VH
`define PLMCR_REGS_VH

// ----------------------------------------------------------------
// Register addresses (5-bit management register numbers)
// ----------------------------------------------------------------
`define PLMCR_ADDR_LOOP 5'h13
`define PLMCR_ADDR_UNUSED20 5'h14
`define PLMCR_ADDR_MGMT 5'h15
`define PLMCR_ADDR_SETUP 5'h16

// ----------------------------------------------------------------
// Loopback select fields
// ----------------------------------------------------------------
`define PLMCR_LOOP_MII 15
`define PLMCR_LOOP_DIG 12
`define PLMCR_LOOP_REP 11
`define PLMCR_LOOP_LDRV 10
`define PLMCR_LOOP_MASK 16'h9C00
`define PLMCR_LOOP_RST 16'h8000

// ----------------------------------------------------------------
// Management options fields
// ----------------------------------------------------------------
`define PLMCR_MGMT_IGN_ST00 2
`define PLMCR_MGMT_NO_PRE 0
`define PLMCR_MGMT_MASK 16'h0005
`define PLMCR_MGMT_RST 16'h0005

// ----------------------------------------------------------------
// Configuration fields
// ----------------------------------------------------------------
`define PLMCR_CFG_CRS_TX 15
`define PLMCR_CFG_FIFO_HI 13
`define PLMCR_CFG_FIFO_LO 12
`define PLMCR_CFG_DS_HI 11
`define PLMCR_CFG_DS_LO 10
`define PLMCR_CFG_TBI_DET 9
`define PLMCR_CFG_TBI_RATE 8
`define PLMCR_CFG_ALT_NP 7
`define PLMCR_CFG_GROUP 6
`define PLMCR_CFG_TXCLK 5
`define PLMCR_CFG_REFCLK 4
`define PLMCR_CFG_IF_HI 2
`define PLMCR_CFG_IF_LO 0
`define PLMCR_CFG_MASK 16'hBFF7
`define PLMCR_CFG_RST_FIXED 16'h1C00

// ----------------------------------------------------------------
// Encodings
// ----------------------------------------------------------------
`define PLMCR_IF_GMII 3'h0
`define PLMCR_IF_TBI 3'h1
`define PLMCR_IF_GMII_GTX 3'h2
`define PLMCR_IF_RSVD 3'h3
`define PLMCR_DS_OFF 2'h0
`define PLMCR_SPD_10 2'h0
`define PLMCR_SPD_100 2'h1
`define PLMCR_SPD_1000 2'h2

// ----------------------------------------------------------------
// Timing counts and output reset values
// ----------------------------------------------------------------
`define PLMCR_STRAP_LOAD 2'h2
`define PLMCR_STRAP_DONE 2'h3
`define PLMCR_DEPTH_RST 6'h10

`endif

// *** plmcr_downshift.v ***
// Automatic speed downshift sequencer
`timescale 1ns/1ps
`default_nettype none

module plmcr_downshift (
	input wire clk_in,
	input wire sys_rst_in,
	input wire [1:0] ds_mode_in,
	input wire an_fail_in,
	input wire link_up_in,
	output reg [1:0] speed_out
);
`include "plmcr_regs.vh"

	reg link_seen_q;

	// ----------------------------------------------------------------
	// Speed stepping
	// ----------------------------------------------------------------
	always @(posedge clk_in) begin
		if (sys_rst_in) begin
			speed_out <= `PLMCR_SPD_1000;
			link_seen_q <= 1'b0;
		end else begin
			link_seen_q <= link_up_in;
			if (link_seen_q && !link_up_in) begin
				speed_out <= `PLMCR_SPD_1000; // [RL11]
			end else if (an_fail_in && !link_up_in) begin
				// Step 1000 -> 100 -> 10 -> 1000, skipping speeds the mode forbids [RL9] [RL10]
				case (speed_out)
					`PLMCR_SPD_1000: begin
						if (ds_mode_in[1])
							speed_out <= `PLMCR_SPD_100;
						else if (ds_mode_in[0])
							speed_out <= `PLMCR_SPD_10;
						else
							speed_out <= `PLMCR_SPD_1000;
					end
					`PLMCR_SPD_100: begin
						if (ds_mode_in[0])
							speed_out <= `PLMCR_SPD_10;
						else
							speed_out <= `PLMCR_SPD_1000;
					end
					default: begin
						speed_out <= `PLMCR_SPD_1000;
					end
				endcase
			end
		end
	end
endmodule // plmcr_downshift

`default_nettype wire

// *** plmcr_top.v ***
// Loopback, management-option and configuration register bank
//
// Overview of operation
// (RL1) Bit 15 selects MII loopback, resets one
// (RL2) Bit 12 selects all-digital loopback, resets zero
// (RL3) Bit 11 selects replica loopback, not 10M
// (RL4) Bit 10 selects line driver loopback
// (RL5) Bit 2 set ignores start-00 frames
// (RL6) Bit 0 set allows preamble-less frames
// (RL7) Config bit 15 enables transmit carrier sense
// (RL8) Bits 13:12 set transmit FIFO depth
// (RL9) Bits 11:10 choose allowed downshift speeds
// (RL10) Failed gigabit negotiation steps down, repeating
// (RL11) Dropped link restarts at highest speed
// (RL12) Bit 9 chooses comma or link detect
// (RL13) Bit 8 chooses full-rate or split clocks
// (RL14) Bit 7 enables manual gigabit next pages
// (RL15) Bit 6 enables group management mode
// (RL16) Bit 5 enables transmit clock output
// (RL17) Bit 4 enables reference clock, strap-inverted
// (RL18) Bits 2:0 select MAC interface, strapped
// (RL19) Code 010 uses GTX clock for GMII
// (RL20) Reserved bits and register read zero
`timescale 1ns/1ps
`default_nettype none

module plmcr_top (
	input wire clk_in,
	input wire sys_rst_in,
	input wire [4:0] mgmt_addr_in,
	input wire [15:0] mgmt_wdata_in,
	input wire mgmt_wr_in,
	input wire mgmt_rd_in,
	input wire refclk_enable_strap_n_in,
	input wire [2:0] host_interface_strap_in,
	input wire an_fail_in,
	input wire link_up_in,
	input wire frame_st00_in,
	input wire frame_pre_seen_in,
	input wire frame_start_in,
	input wire tbi_comma_in,
	input wire tbi_link_in,
	input wire tx_active_in,
	input wire half_duplex_in,
	output reg [15:0] mgmt_rdata_out,
	output reg mgmt_rvalid_out,
	output reg frame_ignore_out,
	output reg frame_error_out,
	output reg loop_mii_out,
	output reg loop_digital_out,
	output reg loop_replica_out,
	output reg loop_line_drv_out,
	output reg crs_out,
	output reg [5:0] tx_fifo_depth_out,
	output reg [1:0] speed_out,
	output reg tbi_rate_full_out,
	output reg alt_next_page_out,
	output reg group_mgmt_out,
	output reg tx_clk_en_out,
	output reg reference_clock_output_en_out,
	output reg [2:0] host_if_mode_out,
	output reg gtx_clocked_out
);
`include "plmcr_regs.vh"

	// ----------------------------------------------------------------
	// Pin synchronisers
	// ----------------------------------------------------------------
	// Strap, negotiation and TBI detect pins come from outside this clock
	reg [7:0] pin_meta_q;
	reg [7:0] pin_sync_q;
	wire [7:0] pin_raw;
	assign pin_raw = {an_fail_in, link_up_in, tbi_comma_in, tbi_link_in,
		refclk_enable_strap_n_in, host_interface_strap_in};

	genvar gi;
	generate
		for (gi = 0; gi < 8; gi = gi + 1) begin : g_sync
			always @(posedge clk_in) begin
				// Zero in reset; the strap load waits until real levels arrive
				if (sys_rst_in) begin
					pin_meta_q[gi] <= 1'b0;
					pin_sync_q[gi] <= 1'b0;
				end else begin
					pin_meta_q[gi] <= pin_raw[gi];
					pin_sync_q[gi] <= pin_meta_q[gi];
				end
			end
		end
	endgenerate

	wire an_fail_s;
	wire link_up_s;
	wire comma_s;
	wire tbi_link_s;
	wire strap_n_s;
	wire [2:0] strap_if_s;
	assign an_fail_s = pin_sync_q[7];
	assign link_up_s = pin_sync_q[6];
	assign comma_s = pin_sync_q[5];
	assign tbi_link_s = pin_sync_q[4];
	assign strap_n_s = pin_sync_q[3];
	assign strap_if_s = pin_sync_q[2:0];

	// ----------------------------------------------------------------
	// Registers
	// ----------------------------------------------------------------
	reg [15:0] loop_q;
	reg [15:0] mgmt_q;
	reg [15:0] cfg_q;
	reg [1:0] strap_cnt_q;
	wire strap_load;
	wire wr_loop;
	wire wr_mgmt;
	wire wr_cfg;

	// Straps are captured on the third edge after reset release so that the
	// synchronisers hold real pin levels rather than their reset zeros.
	// A management write on that same edge is dropped; software is
	// expected to wait for the strap load before its first access.
	assign strap_load = (strap_cnt_q == `PLMCR_STRAP_LOAD);
	// Writes to reserved bits, register 20 and unmapped numbers fall through [RL20]
	assign wr_loop = mgmt_wr_in && !strap_load && (mgmt_addr_in == `PLMCR_ADDR_LOOP);
	assign wr_mgmt = mgmt_wr_in && !strap_load && (mgmt_addr_in == `PLMCR_ADDR_MGMT);
	assign wr_cfg = mgmt_wr_in && !strap_load && (mgmt_addr_in == `PLMCR_ADDR_SETUP);

	always @(posedge clk_in) begin
		if (sys_rst_in) begin
			strap_cnt_q <= 2'h0;
		end else if (strap_cnt_q != `PLMCR_STRAP_DONE) begin
			// Counter parks once the straps are in, so they load only once
			strap_cnt_q <= strap_cnt_q + 2'h1;
		end
	end

	always @(posedge clk_in) begin
		if (sys_rst_in) begin
			loop_q <= `PLMCR_LOOP_RST; // [RL1] [RL2] [RL4]
		end else if (wr_loop) begin
			loop_q <= mgmt_wdata_in & `PLMCR_LOOP_MASK; // [RL20]
		end
	end

	always @(posedge clk_in) begin
		if (sys_rst_in) begin
			mgmt_q <= `PLMCR_MGMT_RST; // [RL5] [RL6]
		end else if (wr_mgmt) begin
			mgmt_q <= mgmt_wdata_in & `PLMCR_MGMT_MASK; // [RL20]
		end
	end

	// Only the strapped fields change at the load; the rest keep their fixed defaults
	always @(posedge clk_in) begin
		if (sys_rst_in) begin
			cfg_q <= `PLMCR_CFG_RST_FIXED; // [RL8] [RL9]
		end else if (strap_load) begin
			cfg_q[`PLMCR_CFG_REFCLK] <= ~strap_n_s; // [RL17]
			cfg_q[`PLMCR_CFG_IF_HI:`PLMCR_CFG_IF_LO] <= strap_if_s; // [RL18]
		end else if (wr_cfg) begin
			cfg_q <= mgmt_wdata_in & `PLMCR_CFG_MASK; // [RL20]
		end
	end

	// ----------------------------------------------------------------
	// Read path
	// ----------------------------------------------------------------
	// Unmapped register numbers read as zero, like register 20
	reg [15:0] rdata_d;
	always @* begin
		case (mgmt_addr_in)
			`PLMCR_ADDR_LOOP: rdata_d = loop_q;
			`PLMCR_ADDR_MGMT: rdata_d = mgmt_q;
			`PLMCR_ADDR_SETUP: rdata_d = cfg_q;
			default: rdata_d = 16'h0000; // [RL20]
		endcase
	end

	// ----------------------------------------------------------------
	// Downshift sequencer
	// ----------------------------------------------------------------
	// Mode comes straight from the register; a new mode acts on the next failure [RL9]
	wire [1:0] speed_d;
	plmcr_downshift u_downshift (
		.clk_in(clk_in),
		.sys_rst_in(sys_rst_in),
		.ds_mode_in(cfg_q[`PLMCR_CFG_DS_HI:`PLMCR_CFG_DS_LO]),
		.an_fail_in(an_fail_s),
		.link_up_in(link_up_s),
		.speed_out(speed_d)
	);

	// ----------------------------------------------------------------
	// Derived controls
	// ----------------------------------------------------------------
	wire is_tbi;
	wire [2:0] if_mode;
	wire st00_ignore;
	wire pre_missing;
	reg [5:0] depth_d;
	// Reserved interface code 011 is kept and reported as written
	assign if_mode = cfg_q[`PLMCR_CFG_IF_HI:`PLMCR_CFG_IF_LO];
	assign is_tbi = (if_mode == `PLMCR_IF_TBI);
	assign st00_ignore = mgmt_q[`PLMCR_MGMT_IGN_ST00];
	// A frame lacking preamble is only wrong while preamble is required
	assign pre_missing = !frame_pre_seen_in && !mgmt_q[`PLMCR_MGMT_NO_PRE]; // [RL6]

	// Depth is the plus-or-minus span in entries, not a raw field copy
	always @* begin
		case (cfg_q[`PLMCR_CFG_FIFO_HI:`PLMCR_CFG_FIFO_LO]) // [RL8]
			2'h0: depth_d = 6'h08;
			2'h1: depth_d = 6'h10;
			2'h2: depth_d = 6'h18;
			default: depth_d = 6'h20;
		endcase
	end

	// ----------------------------------------------------------------
	// Read response
	// ----------------------------------------------------------------
	// Data is forced to zero outside a read so an idle bus never shows stale contents
	always @(posedge clk_in) begin
		if (sys_rst_in) begin
			mgmt_rdata_out <= 16'h0000;
			mgmt_rvalid_out <= 1'b0;
		end else begin
			mgmt_rdata_out <= mgmt_rd_in ? rdata_d : 16'h0000; // [RL20]
			mgmt_rvalid_out <= mgmt_rd_in;
		end
	end

	// ----------------------------------------------------------------
	// Frame screening
	// ----------------------------------------------------------------
	// Both flags may pulse together: a start-00 frame can also lack its preamble
	always @(posedge clk_in) begin
		if (sys_rst_in) begin
			frame_ignore_out <= 1'b0;
			frame_error_out <= 1'b0;
		end else begin
			frame_ignore_out <= frame_start_in && frame_st00_in && st00_ignore; // [RL5]
			frame_error_out <= frame_start_in && ((frame_st00_in && !st00_ignore) || pre_missing); // [RL5] [RL6]
		end
	end

	// ----------------------------------------------------------------
	// Loopback selects
	// ----------------------------------------------------------------
	always @(posedge clk_in) begin
		if (sys_rst_in) begin
			loop_mii_out <= 1'b0;
			loop_digital_out <= 1'b0;
			loop_replica_out <= 1'b0;
			loop_line_drv_out <= 1'b0;
		end else begin
			loop_mii_out <= loop_q[`PLMCR_LOOP_MII]; // [RL1]
			loop_digital_out <= loop_q[`PLMCR_LOOP_DIG]; // [RL2]
			// Replica path does not exist at 10 Mb/s; using the internal speed makes
			// the select drop on the same edge as the speed output changes
			loop_replica_out <= loop_q[`PLMCR_LOOP_REP] && (speed_d != `PLMCR_SPD_10); // [RL3]
			loop_line_drv_out <= loop_q[`PLMCR_LOOP_LDRV]; // [RL4]
		end
	end

	// ----------------------------------------------------------------
	// Carrier sense
	// ----------------------------------------------------------------
	// Comma and link detect pass the pin synchronisers, so crs_out lags their pins by three edges
	always @(posedge clk_in) begin
		if (sys_rst_in) begin
			crs_out <= 1'b0;
		end else if (is_tbi) begin
			crs_out <= cfg_q[`PLMCR_CFG_TBI_DET] ? comma_s : tbi_link_s; // [RL12]
		end else begin
			crs_out <= cfg_q[`PLMCR_CFG_CRS_TX] && tx_active_in && half_duplex_in; // [RL7]
		end
	end

	// ----------------------------------------------------------------
	// Configuration outputs
	// ----------------------------------------------------------------
	always @(posedge clk_in) begin
		if (sys_rst_in) begin
			tx_fifo_depth_out <= `PLMCR_DEPTH_RST;
			speed_out <= `PLMCR_SPD_1000;
			tbi_rate_full_out <= 1'b0;
			alt_next_page_out <= 1'b0;
			group_mgmt_out <= 1'b0;
			tx_clk_en_out <= 1'b0;
			reference_clock_output_en_out <= 1'b0;
			host_if_mode_out <= `PLMCR_IF_GMII;
			gtx_clocked_out <= 1'b0;
		end else begin
			tx_fifo_depth_out <= depth_d; // [RL8]
			speed_out <= speed_d; // [RL10]
			tbi_rate_full_out <= cfg_q[`PLMCR_CFG_TBI_RATE]; // [RL13]
			alt_next_page_out <= cfg_q[`PLMCR_CFG_ALT_NP]; // [RL14]
			group_mgmt_out <= cfg_q[`PLMCR_CFG_GROUP]; // [RL15]
			tx_clk_en_out <= cfg_q[`PLMCR_CFG_TXCLK]; // [RL16]
			reference_clock_output_en_out <= cfg_q[`PLMCR_CFG_REFCLK]; // [RL17]
			host_if_mode_out <= if_mode; // [RL18]
			gtx_clocked_out <= (if_mode == `PLMCR_IF_GMII_GTX); // [RL19]
		end
	end
endmodule // plmcr_top

`default_nettype wire

// *** plmcr_station.sv ***
// Management station model that issues one-cycle register strobes
`timescale 1ns/1ps
`default_nettype none
module plmcr_station (
	input wire logic clk_in,
	input wire logic go_in,
	input wire logic wr_in,
	input wire logic [4:0] addr_in,
	input wire logic [15:0] wdata_in,
	output logic mgmt_wr_out,
	output logic mgmt_rd_out,
	output logic [4:0] mgmt_addr_out,
	output logic [15:0] mgmt_wdata_out
);
	// ------
	// Driver
	// ------
	initial {mgmt_wr_out, mgmt_rd_out, mgmt_addr_out, mgmt_wdata_out} = '0;
	// Idle address and data toggle, so a stale value never passes for a live one
	always @(negedge clk_in) begin
		mgmt_wr_out <= go_in & wr_in;
		mgmt_rd_out <= go_in & ~wr_in;
		mgmt_addr_out <= go_in ? addr_in : ~mgmt_addr_out;
		mgmt_wdata_out <= go_in ? wdata_in : ~mgmt_wdata_out;
	end
endmodule // plmcr_station
`default_nettype wire

// *** plmcr_top_monitor.sv ***
// Concurrent checks on the register bank ports
`timescale 1ns/1ps
`default_nettype none
`include "plmcr_regs.vh"
module plmcr_top_monitor (
	input wire logic clk_in,
	input wire logic sys_rst_in,
	input wire logic [4:0] mgmt_addr_in,
	input wire logic [15:0] mgmt_wdata_in,
	input wire logic mgmt_wr_in,
	input wire logic mgmt_rd_in,
	input wire logic frame_st00_in,
	input wire logic frame_pre_seen_in,
	input wire logic frame_start_in,
	input wire logic [15:0] mgmt_rdata_out,
	input wire logic mgmt_rvalid_out,
	input wire logic frame_ignore_out,
	input wire logic frame_error_out,
	input wire logic loop_mii_out,
	input wire logic loop_digital_out,
	input wire logic loop_replica_out,
	input wire logic [5:0] tx_fifo_depth_out,
	input wire logic [1:0] speed_out
);
	// ------
	// Checks
	// ------
	wire logic wr_loop = mgmt_wr_in && mgmt_addr_in == `PLMCR_ADDR_LOOP;
	wire logic wr_cfg = mgmt_wr_in && mgmt_addr_in == `PLMCR_ADDR_SETUP;
	wire logic [2:0] fifo_w = {1'b0, mgmt_wdata_in[13:12]} + 3'h1;
	default clocking @(posedge clk_in); endclocking
	default disable iff (sys_rst_in);
	AST_LOOP_MII: assert property (wr_loop |=> ##1 loop_mii_out == $past(mgmt_wdata_in[15], 2))
		else $error("mii loopback not as written");
	AST_LOOP_DIG: assert property (wr_loop |=> ##1 loop_digital_out == $past(mgmt_wdata_in[12], 2))
		else $error("digital loopback not as written");
	AST_REP_10M: assert property (speed_out == 2'h0 && $past(speed_out) == 2'h0 |-> !loop_replica_out)
		else $error("replica loopback at 10M");
	AST_IGN: assert property (frame_start_in && !frame_st00_in |=> !frame_ignore_out)
		else $error("ignore without st00 frame");
	AST_PRE: assert property (frame_start_in && frame_pre_seen_in && !frame_st00_in |=> !frame_error_out)
		else $error("error on good frame");
	// A setup write at the strap load edge is lost, so that window is left out
	AST_FIFO: assert property (wr_cfg && !$past(sys_rst_in, 3) |=> ##1 tx_fifo_depth_out == {$past(fifo_w, 2), 3'h0})
		else $error("fifo depth not as written");
	AST_RD_RSVD: assert property (mgmt_rd_in && mgmt_addr_in == 5'h14 |=> mgmt_rvalid_out && mgmt_rdata_out == 16'h0000)
		else $error("reserved register read not zero");
	AST_RD_IDLE: assert property (!mgmt_rd_in |=> !mgmt_rvalid_out && mgmt_rdata_out == 16'h0000)
		else $error("read data without read");
	cover property (frame_ignore_out);
	cover property (speed_out == 2'h0 && loop_digital_out);
	cover property (mgmt_rvalid_out && mgmt_rdata_out != 16'h0000);
endmodule // plmcr_top_monitor
`default_nettype wire

// *** plmcr_top_tb_top.sv ***
// Self-checking bench for the register bank
`timescale 1ns/1ps
`default_nettype none
`include "plmcr_regs.vh"
module plmcr_top_tb_top;
	logic clk_in = 1'b0, sys_rst_in = 1'b1, go = 1'b0, wr = 1'b0, mgmt_wr_in, mgmt_rd_in;
	logic an_fail_in = 1'b0, link_up_in = 1'b0, frame_st00_in = 1'b0, frame_pre_seen_in = 1'b0;
	logic frame_start_in = 1'b0, tbi_comma_in = 1'b0, tbi_link_in = 1'b0, tx_active_in = 1'b0;
	logic half_duplex_in = 1'b0, refclk_enable_strap_n_in = 1'b0;
	logic [2:0] host_interface_strap_in = 3'h5, host_if_mode_out;
	logic [4:0] addr = 5'h00, mgmt_addr_in;
	logic [15:0] wdata = 16'h0000, mgmt_wdata_in, mgmt_rdata_out, d, r;
	logic mgmt_rvalid_out, frame_ignore_out, frame_error_out, loop_mii_out, loop_digital_out, loop_replica_out;
	logic loop_line_drv_out, crs_out, tbi_rate_full_out, alt_next_page_out, group_mgmt_out, tx_clk_en_out;
	logic reference_clock_output_en_out, gtx_clocked_out;
	logic [5:0] tx_fifo_depth_out;
	logic [1:0] speed_out, s;
	logic [31:0] seed = 32'h0000_1bbd;
	int miscompares = 0, comparisons = 0;
	plmcr_station i_sta (.clk_in(clk_in), .go_in(go), .wr_in(wr), .addr_in(addr), .wdata_in(wdata),
		.mgmt_wr_out(mgmt_wr_in), .mgmt_rd_out(mgmt_rd_in), .mgmt_addr_out(mgmt_addr_in), .mgmt_wdata_out(mgmt_wdata_in));
	plmcr_top i_dut (.*);
	always #2.5 clk_in = ~clk_in;
	// --------------
	// Bench routines
	// --------------
	function automatic logic [15:0] rnd();
		seed = {seed[30:0], 1'b0} ^ (seed[31] ? 32'h8020_0003 : 32'h0000_0000);
		return seed[15:0];
	endfunction
	function automatic logic [14:0] cfg_exp(input logic [15:0] v);
		return {v[8], v[7], v[6], v[5], v[4], v[2:0], v[2:0] == 3'h2, {1'b0, v[13:12]} + 3'h1, 3'h0};
	endfunction
	function automatic logic [1:0] ds_next(input logic [1:0] m, input logic [1:0] sp);
		if (m == `PLMCR_DS_OFF) return `PLMCR_SPD_1000;
		if (sp == `PLMCR_SPD_1000 && m[1]) return `PLMCR_SPD_100;
		if (sp != `PLMCR_SPD_10 && m[0]) return `PLMCR_SPD_10;
		return `PLMCR_SPD_1000;
	endfunction
	task automatic chk(input string n, input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			miscompares++;
			$display("unexpected %s: expected %h seen %h", n, exp, seen);
		end
	endtask
	task automatic bus(input logic w, input logic [4:0] a, input logic [15:0] v, input logic [15:0] exp);
		@(posedge clk_in);
		go <= 1'b1;
		wr <= w;
		addr <= a;
		wdata <= v;
		@(posedge clk_in);
		go <= 1'b0;
		// Read data stands for one cycle only, so look at it in the half cycle after it is taken
		@(negedge clk_in);
		if (!w) chk("rdata", {mgmt_rvalid_out, mgmt_rdata_out}, {1'b1, exp});
	endtask
	task automatic give_verdict();
		$display("comparisons %0d miscompares %0d", comparisons, miscompares);
		if (miscompares == 0 && comparisons > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	initial begin
		#100000;
		miscompares++;
		give_verdict();
	end
	initial begin
		for (int p = 0; p < 2; p++) begin
			sys_rst_in = 1'b1;
			refclk_enable_strap_n_in = p[0];
			host_interface_strap_in = p[0] ? 3'h2 : 3'h5;
			repeat (10) @(negedge clk_in);
			sys_rst_in = 1'b0;
			s = `PLMCR_SPD_1000;
			repeat (5) @(negedge clk_in);
			bus(0, `PLMCR_ADDR_SETUP, 0, `PLMCR_CFG_RST_FIXED | {11'h000, !p[0], 1'b0, host_interface_strap_in});
			bus(0, `PLMCR_ADDR_LOOP, 0, `PLMCR_LOOP_RST);
			bus(0, `PLMCR_ADDR_MGMT, 0, `PLMCR_MGMT_RST);
			bus(0, 5'h00, 0, 0);
			for (int i = 0; i < 12; i++) begin
				r = rnd();
				d = rnd();
				// First passes force TBI, GTX-clocked and the reserved interface code
				if (i < 3) d[2:0] = i[2:0] + 3'h1;
				{tx_active_in, half_duplex_in, tbi_comma_in, tbi_link_in} = r[3:0];
				bus(1, `PLMCR_ADDR_SETUP, d, 0);
				repeat (2) @(negedge clk_in);
				chk("setup", {tbi_rate_full_out, alt_next_page_out, group_mgmt_out, tx_clk_en_out,
					reference_clock_output_en_out, host_if_mode_out, gtx_clocked_out, tx_fifo_depth_out},
					cfg_exp(d));
				chk("crs", crs_out, d[2:0] == `PLMCR_IF_TBI ? (d[9] ? r[1] : r[0]) : d[15] & r[3] & r[2]);
				bus(0, `PLMCR_ADDR_SETUP, 0, d & `PLMCR_CFG_MASK);
				bus(1, `PLMCR_ADDR_LOOP, r, 0);
				repeat (2) @(negedge clk_in);
				chk("loop", {loop_mii_out, loop_digital_out, loop_replica_out, loop_line_drv_out},
					{r[15], r[12], r[11], r[10]});
				bus(0, `PLMCR_ADDR_LOOP, 0, r & `PLMCR_LOOP_MASK);
				bus(1, `PLMCR_ADDR_UNUSED20, d, 0);
				bus(0, `PLMCR_ADDR_UNUSED20, 0, 0);
				bus(1, `PLMCR_ADDR_MGMT, d, 0);
				frame_st00_in = r[4];
				frame_pre_seen_in = r[5];
				frame_start_in = 1'b1;
				@(negedge clk_in);
				frame_start_in = 1'b0;
				chk("frame", {frame_ignore_out, frame_error_out}, {r[4] & d[2], r[4] & !d[2] | !r[5] & !d[0]});
				bus(0, `PLMCR_ADDR_MGMT, 0, d & `PLMCR_MGMT_MASK);
			end
			bus(1, `PLMCR_ADDR_LOOP, `PLMCR_LOOP_MASK, 0);
			for (int m = 3; m >= 0; m--) begin
				bus(1, `PLMCR_ADDR_SETUP, {4'h1, m[1:0], 10'h000}, 0);
				link_up_in = 1'b1;
				repeat (6) @(negedge clk_in);
				link_up_in = 1'b0;
				repeat (8) @(negedge clk_in);
				s = `PLMCR_SPD_1000;
				chk("restart", speed_out, s);
				for (int k = 0; k < 4; k++) begin
					an_fail_in = 1'b1;
					@(negedge clk_in);
					an_fail_in = 1'b0;
					s = ds_next(m[1:0], s);
					repeat (6) @(negedge clk_in);
					chk("speed", {speed_out, loop_replica_out}, {s, s != `PLMCR_SPD_10});
				end
			end
		end
		give_verdict();
	end
endmodule // plmcr_top_tb_top
bind plmcr_top plmcr_top_monitor i_mon (.*);
`default_nettype wire
